// [twa_defs.svh]
`ifndef TWA_DEFS_SVH
`define TWA_DEFS_SVH
// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 32'd4
`define SAMPLE_BASE_NS 32'd15600
`define BASE_CYCLES (`SAMPLE_BASE_NS / `CLK_PERIOD_NS)
// ****************************************
// Limits and defaults
// ****************************************
`define MAX_TOTAL_POINTS 26'd4096
`define DEF_POINTS 13'd2048
`define DEF_COUNT 13'd1
`define DEF_PERIOD_MULT 20'd1
`define OFFSET_MIN -32'sd4096
`define OFFSET_MAX 32'sd2000000000
`define FIFO_DEPTH 32
`endif

// [twa_pkg.sv]
package twa_pkg;
   // ****************************************
   // Commands and modes
   // ****************************************
   typedef enum logic [3:0] {
      OP_RESET_DEF, OP_SET_PERIOD, OP_SET_POINTS, OP_SET_COUNT,
      OP_SET_OFFSET, OP_SET_DETECT, OP_SET_FUNC, OP_SET_SOURCE,
      OP_SET_LEVEL, OP_SET_HYST, OP_SET_SLOPE, OP_INIT,
      OP_ABORT, OP_TRIGGER, OP_FETCH, OP_MEASURE
   } cmd_op_t;
   typedef enum logic [2:0] {K_ARRAY, K_MAX, K_MIN, K_HIGH, K_LOW} query_kind_t;
   typedef enum logic [1:0] {SLOPE_POS, SLOPE_NEG, SLOPE_EITHER} slope_t;
   typedef enum logic [1:0] {ACQ_IDLE, ACQ_ARMED, ACQ_DELAY, ACQ_FILL} acq_state_t;
   typedef enum logic [1:0] {QRY_IDLE, QRY_WAIT, QRY_SCAN, QRY_PUSH} qry_state_t;
   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic valid;
      cmd_op_t op;
      logic [31:0] arg;
   } cmd_t;
   typedef struct packed {
      logic initiated;
      logic waiting_trigger;
      logic query_busy;
      logic record_valid;
   } status_t;
endpackage

// [twa_acq.sv]
// Functional notes
// RULE1: Selectable detector: full waveform or dc only
// RULE2: Report max or min of record
// RULE3: Report high-level and low-level averages
// RULE4: Reset command sets 15.6 us period
// RULE5: Default record is 2048 points
// RULE6: Points and interval are programmable
// RULE7: Interval rounds to nearest base multiple
// RULE8: Trigger count averages several acquisitions
// RULE9: Re-arm after each acquisition automatically
// RULE10: Count times points over 4096 errors
// RULE11: Sample continuously once initiated
// RULE12: Offset accepted from -4096 to 2e9
// RULE13: Negative offset keeps pre-trigger samples
// RULE14: Zero offset starts at the trigger
// RULE15: Positive offset delays storing after trigger
// RULE16: Measure query always acquires fresh data; code starts one only when idle, else waits and reads the running one
// RULE17: Fetch query computes from stored record
// RULE18: Internal trigger: level, slope, hysteresis
// RULE19: Idle after completion, triggers then ignored
// RULE20: Fetch waits for unfinished acquisition
// RULE21: Bad offset errors, old offset kept
`include "twa_defs.svh"

// ****************************************
// Result FIFO
// ****************************************
module stream_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr;
   logic [AW-1:0] rd;
   logic [AW:0] cnt;
   logic push;
   logic load;
   assign o_in_ready = cnt != (AW+1)'(DEPTH);
   assign push = i_in_valid && o_in_ready;
   assign load = cnt != '0 && (!o_out_valid || i_out_ready);
   always_ff @(posedge i_clk_sys)
   begin
      if (push)
      begin
         mem[wr] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr <= '0;
         rd <= '0;
         cnt <= '0;
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end
      else
      begin
         wr <= wr + AW'(push);
         rd <= rd + AW'(load);
         cnt <= cnt + (AW+1)'(push) - (AW+1)'(load);
         if (load)
         begin
            o_out_valid <= 1'b1;
            o_out_data <= mem[rd];
         end
         else if (i_out_ready)
         begin
            o_out_valid <= 1'b0;
         end
      end
   end
endmodule // stream_fifo

// ****************************************
// Acquisition top
// ****************************************
module twa_acq #(
   parameter int SAMPLE_W = 16,
   parameter int MAX_TOTAL = 4096,
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire twa_pkg::cmd_t i_cmd,
   input wire logic signed [SAMPLE_W-1:0] i_conv_data,
   output logic o_full_waveform_detector,
   output logic o_conv_current,
   output logic o_err,
   output twa_pkg::status_t o_status,
   output logic o_res_valid,
   output logic [SAMPLE_W-1:0] o_res_data,
   input wire logic i_res_ready
);
   localparam int IW = $clog2(MAX_TOTAL);
   localparam int SW = SAMPLE_W + 14;
   localparam int BASE = `BASE_CYCLES;
   // ****************************************
   // Configuration
   // ****************************************
   logic [19:0] period_mult;
   logic [12:0] points;
   logic [12:0] count;
   logic signed [31:0] offset;
   logic trig_bus;
   logic signed [SAMPLE_W-1:0] level;
   logic signed [SAMPLE_W-1:0] hyst;
   twa_pkg::slope_t slope;
   twa_pkg::acq_state_t state;
   twa_pkg::qry_state_t qst;
   logic cv;
   logic [32:0] rnd;
   logic [25:0] prod_pts;
   logic [25:0] prod_cnt;
   logic pts_ok;
   logic cnt_ok;
   logic off_ok;
   logic q_cmd;
   assign cv = i_cmd.valid;
   assign q_cmd = cv && (i_cmd.op == twa_pkg::OP_FETCH || i_cmd.op == twa_pkg::OP_MEASURE);
   assign rnd = ({1'b0, i_cmd.arg} + 33'(`SAMPLE_BASE_NS / 2)) / 33'(`SAMPLE_BASE_NS); // RULE7
   assign prod_pts = 26'(i_cmd.arg[12:0]) * 26'(count);
   assign prod_cnt = 26'(i_cmd.arg[12:0]) * 26'(points);
   assign pts_ok = i_cmd.arg != '0 && i_cmd.arg <= 32'(MAX_TOTAL)
      && prod_pts <= `MAX_TOTAL_POINTS; // RULE10
   assign cnt_ok = i_cmd.arg != '0 && i_cmd.arg <= 32'(MAX_TOTAL)
      && prod_cnt <= `MAX_TOTAL_POINTS; // RULE10
   assign off_ok = $signed(i_cmd.arg) >= `OFFSET_MIN
      && $signed(i_cmd.arg) <= `OFFSET_MAX; // RULE12
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         period_mult <= `DEF_PERIOD_MULT;
         points <= `DEF_POINTS;
         count <= `DEF_COUNT;
         offset <= '0;
         o_full_waveform_detector <= 1'b1;
         o_conv_current <= 1'b0;
         trig_bus <= 1'b1;
         level <= '0;
         hyst <= '0;
         slope <= twa_pkg::SLOPE_POS;
         o_err <= 1'b0;
      end
      else
      begin
         o_err <= 1'b0;
         if (cv)
         begin
            case (i_cmd.op)
               twa_pkg::OP_RESET_DEF:
               begin
                  period_mult <= `DEF_PERIOD_MULT; // RULE4
                  points <= `DEF_POINTS; // RULE5
                  count <= `DEF_COUNT;
                  offset <= '0;
                  o_full_waveform_detector <= 1'b1;
               end
               twa_pkg::OP_SET_PERIOD:
                  period_mult <= rnd == '0 ? 20'd1 : rnd[19:0]; // RULE6 RULE7
               twa_pkg::OP_SET_POINTS:
                  if (pts_ok) points <= i_cmd.arg[12:0]; // RULE6
                  else o_err <= 1'b1; // RULE10
               twa_pkg::OP_SET_COUNT:
                  if (cnt_ok) count <= i_cmd.arg[12:0]; // RULE8
                  else o_err <= 1'b1; // RULE10
               twa_pkg::OP_SET_OFFSET:
                  if (off_ok) offset <= $signed(i_cmd.arg); // RULE12
                  else o_err <= 1'b1; // RULE21
               twa_pkg::OP_SET_DETECT: o_full_waveform_detector <= i_cmd.arg[0]; // RULE1
               twa_pkg::OP_SET_FUNC: o_conv_current <= i_cmd.arg[0];
               twa_pkg::OP_SET_SOURCE: trig_bus <= i_cmd.arg[0];
               twa_pkg::OP_SET_LEVEL: level <= i_cmd.arg[SAMPLE_W-1:0];
               twa_pkg::OP_SET_HYST: hyst <= i_cmd.arg[SAMPLE_W-1:0];
               twa_pkg::OP_SET_SLOPE: slope <= twa_pkg::slope_t'(i_cmd.arg[1:0]);
               twa_pkg::OP_FETCH, twa_pkg::OP_MEASURE:
                  if (qst != twa_pkg::QRY_IDLE) o_err <= 1'b1;
               default: ;
            endcase
         end
      end
   end
   // ****************************************
   // Sample clock
   // ****************************************
   logic [11:0] base_cnt;
   logic base_tick;
   logic [19:0] per_cnt;
   logic tick;
   logic signed [SAMPLE_W-1:0] sample;
   // Free running, yet pre-trigger history is fresh only if kpre samples are stored between arming and trigger
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         base_cnt <= '0;
         base_tick <= 1'b0;
         per_cnt <= '0;
         tick <= 1'b0;
         sample <= '0;
      end
      else
      begin
         base_tick <= base_cnt == 12'(BASE - 1); // RULE4
         base_cnt <= base_cnt == 12'(BASE - 1) ? 12'h000 : base_cnt + 12'h001;
         tick <= 1'b0;
         if (base_tick)
         begin
            if (per_cnt >= period_mult - 20'h00001)
            begin
               per_cnt <= '0;
               tick <= 1'b1; // RULE11
               sample <= i_conv_data;
            end
            else
               per_cnt <= per_cnt + 20'h00001;
         end
      end
   end
   // ****************************************
   // Trigger and capture
   // ****************************************
   logic signed [SAMPLE_W-1:0] mem [MAX_TOTAL];
   logic [IW-1:0] start_mem [MAX_TOTAL];
   logic [IW-1:0] acq_idx;
   logic [IW-1:0] base;
   logic [IW-1:0] wp;
   logic [IW-1:0] wp_inc;
   logic [12:0] rem;
   logic [12:0] kpre;
   logic [12:0] post_first;
   logic [30:0] dly;
   logic seen_lo;
   logic seen_hi;
   logic pend;
   logic rec_valid;
   logic int_hit;
   logic trig_now;
   logic mem_we;
   logic finish;
   logic start_cmd;
   logic signed [SAMPLE_W:0] lvl_lo;
   logic signed [SAMPLE_W:0] lvl_hi;
   assign lvl_lo = level - hyst;
   assign lvl_hi = level + hyst;
   always_comb
   begin
      case (slope) // RULE18
         twa_pkg::SLOPE_POS: int_hit = seen_lo && sample >= level;
         twa_pkg::SLOPE_NEG: int_hit = seen_hi && sample <= level;
         default: int_hit = (seen_lo && sample >= level) || (seen_hi && sample <= level);
      endcase
   end
   assign start_cmd = cv && state == twa_pkg::ACQ_IDLE && qst == twa_pkg::QRY_IDLE
      && (i_cmd.op == twa_pkg::OP_INIT || i_cmd.op == twa_pkg::OP_MEASURE);
   assign trig_now = state == twa_pkg::ACQ_ARMED && tick && (pend || (!trig_bus && int_hit));
   assign wp_inc = 13'(wp) == points - 13'h0001 ? '0 : wp + IW'(1);
   assign kpre = offset >= 0 ? 13'h0000 : (13'(-offset) >= points ? points - 13'h0001
      : 13'(-offset)); // RULE13
   assign post_first = points - kpre - 13'h0001; // RULE14
   assign mem_we = tick && ((state == twa_pkg::ACQ_ARMED && !(trig_now && offset > 0))
      || state == twa_pkg::ACQ_FILL); // RULE15
   assign finish = tick && ((trig_now && offset <= 0 && post_first == '0)
      || (state == twa_pkg::ACQ_FILL && rem == 13'h0001));
   always_ff @(posedge i_clk_sys)
   begin
      if (mem_we)
      begin
         mem[base + wp] <= sample;
      end
      if (finish)
      begin
         start_mem[acq_idx] <= wp_inc;
      end
   end
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= twa_pkg::ACQ_IDLE;
         acq_idx <= '0;
         base <= '0;
         wp <= '0;
         rem <= '0;
         dly <= '0;
         seen_lo <= 1'b0;
         seen_hi <= 1'b0;
         pend <= 1'b0;
         rec_valid <= 1'b0;
      end
      else if (start_cmd)
      begin
         state <= twa_pkg::ACQ_ARMED;
         acq_idx <= '0;
         base <= '0;
         wp <= '0;
         seen_lo <= 1'b0;
         seen_hi <= 1'b0;
         pend <= i_cmd.op == twa_pkg::OP_MEASURE; // RULE16
         rec_valid <= 1'b0;
      end
      else if (cv && (i_cmd.op == twa_pkg::OP_ABORT || i_cmd.op == twa_pkg::OP_RESET_DEF))
      begin
         state <= twa_pkg::ACQ_IDLE;
         pend <= 1'b0;
      end
      else
      begin
         if (mem_we)
            wp <= wp_inc; // RULE11
         if (state == twa_pkg::ACQ_ARMED && cv && i_cmd.op == twa_pkg::OP_TRIGGER
            && (i_cmd.arg[0] || trig_bus))
            pend <= 1'b1;
         case (state)
            twa_pkg::ACQ_ARMED:
               if (tick)
               begin
                  seen_lo <= seen_lo || sample < lvl_lo; // RULE18
                  seen_hi <= seen_hi || sample > lvl_hi;
                  if (trig_now)
                  begin
                     pend <= 1'b0;
                     if (offset > 0)
                     begin
                        dly <= offset[30:0] - 31'h00000001; // RULE15
                        state <= offset == 1 ? twa_pkg::ACQ_FILL : twa_pkg::ACQ_DELAY;
                        rem <= points;
                     end
                     else if (post_first != '0)
                     begin
                        state <= twa_pkg::ACQ_FILL;
                        rem <= post_first;
                     end
                  end
               end
            twa_pkg::ACQ_DELAY:
               if (tick)
               begin
                  dly <= dly - 31'h00000001;
                  if (dly == 31'h00000001)
                     state <= twa_pkg::ACQ_FILL;
               end
            twa_pkg::ACQ_FILL:
               if (tick)
                  rem <= rem - 13'h0001;
            default: ;
         endcase
         if (finish)
         begin
            if (13'(acq_idx) == count - 13'h0001)
            begin
               state <= twa_pkg::ACQ_IDLE; // RULE19
               rec_valid <= 1'b1;
            end
            else
            begin
               state <= twa_pkg::ACQ_ARMED; // RULE9
               acq_idx <= acq_idx + IW'(1);
               base <= base + points[IW-1:0];
               wp <= '0;
               seen_lo <= 1'b0;
               seen_hi <= 1'b0;
            end
         end
      end
   end
   // ****************************************
   // Query engine
   // ****************************************
   twa_pkg::query_kind_t kind;
   logic [1:0] pass;
   logic [12:0] qi;
   logic [12:0] qj;
   logic [IW-1:0] qbase;
   logic signed [SW-1:0] sum;
   logic signed [SW-1:0] acc;
   logic signed [SW-1:0] avg;
   logic [12:0] s;
   logic [12:0] s_m;
   logic signed [SAMPLE_W-1:0] maxv;
   logic signed [SAMPLE_W-1:0] minv;
   logic signed [SW-1:0] sum_hi;
   logic signed [SW-1:0] sum_lo;
   logic [12:0] n_hi;
   logic [12:0] n_lo;
   logic signed [SAMPLE_W:0] mid;
   logic signed [SAMPLE_W-1:0] scalar;
   logic last_j;
   logic last_i;
   logic f_ready;
   logic f_valid;
   logic advance;
   assign s = 13'(start_mem[qj[IW-1:0]]) + qi;
   assign s_m = s >= points ? s - points : s;
   assign acc = sum + SW'(mem[qbase + s_m[IW-1:0]]);
   assign avg = acc / $signed({1'b0, count}); // RULE8
   assign last_j = qj == count - 13'h0001;
   assign last_i = qi == points - 13'h0001;
   assign mid = (maxv + minv) >>> 1;
   assign f_valid = qst == twa_pkg::QRY_PUSH || (qst == twa_pkg::QRY_SCAN
      && pass == 2'd2 && last_j);
   assign advance = !(pass == 2'd2 && last_j && !f_ready);
   always_comb
   begin
      case (kind)
         twa_pkg::K_MIN: scalar = minv; // RULE2
         twa_pkg::K_HIGH: scalar = n_hi == '0 ? maxv
            : SAMPLE_W'(sum_hi / $signed({1'b0, n_hi})); // RULE3
         twa_pkg::K_LOW: scalar = n_lo == '0 ? minv
            : SAMPLE_W'(sum_lo / $signed({1'b0, n_lo})); // RULE3
         default: scalar = maxv; // RULE2
      endcase
   end
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         qst <= twa_pkg::QRY_IDLE;
         kind <= twa_pkg::K_ARRAY;
         pass <= '0;
         qi <= '0;
         qj <= '0;
         qbase <= '0;
         sum <= '0;
         maxv <= '0;
         minv <= '0;
         sum_hi <= '0;
         sum_lo <= '0;
         n_hi <= '0;
         n_lo <= '0;
      end
      else
      begin
         case (qst)
            twa_pkg::QRY_IDLE:
               if (q_cmd)
               begin
                  kind <= twa_pkg::query_kind_t'(i_cmd.arg[2:0]);
                  qst <= twa_pkg::QRY_WAIT;
               end
            twa_pkg::QRY_WAIT:
               // Held off while an initiated acquisition is running
               if (state == twa_pkg::ACQ_IDLE) // RULE20
               begin
                  qst <= rec_valid ? twa_pkg::QRY_SCAN : twa_pkg::QRY_IDLE; // RULE17
                  pass <= kind == twa_pkg::K_ARRAY ? 2'd2 : 2'd0;
                  qi <= '0;
                  qj <= '0;
                  qbase <= '0;
                  sum <= '0;
                  sum_hi <= '0;
                  sum_lo <= '0;
                  n_hi <= '0;
                  n_lo <= '0;
               end
            twa_pkg::QRY_SCAN:
               if (advance)
               begin
                  if (last_j)
                  begin
                     sum <= '0;
                     qj <= '0;
                     qbase <= '0;
                     qi <= last_i ? 13'h0000 : qi + 13'h0001;
                     if (pass == 2'd0)
                     begin
                        if (qi == '0 || SAMPLE_W'(avg) > maxv)
                           maxv <= SAMPLE_W'(avg); // RULE2
                        if (qi == '0 || SAMPLE_W'(avg) < minv)
                           minv <= SAMPLE_W'(avg);
                     end
                     else if (pass == 2'd1)
                     begin
                        if (avg > SW'(mid)) // RULE3
                        begin
                           sum_hi <= sum_hi + avg;
                           n_hi <= n_hi + 13'h0001;
                        end
                        else
                        begin
                           sum_lo <= sum_lo + avg;
                           n_lo <= n_lo + 13'h0001;
                        end
                     end
                     if (last_i)
                     begin
                        if (pass == 2'd2)
                           qst <= twa_pkg::QRY_IDLE;
                        else if (pass == 2'd0 && (kind == twa_pkg::K_HIGH
                           || kind == twa_pkg::K_LOW))
                           pass <= 2'd1;
                        else
                           qst <= twa_pkg::QRY_PUSH;
                     end
                  end
                  else
                  begin
                     qj <= qj + 13'h0001;
                     qbase <= qbase + points[IW-1:0];
                     sum <= acc; // RULE8
                  end
               end
            default:
               if (f_ready)
                  qst <= twa_pkg::QRY_IDLE;
         endcase
      end
   end
   // Stalls the scan when the reader lags
   stream_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_in_valid(f_valid),
      .i_in_data(qst == twa_pkg::QRY_PUSH ? scalar : SAMPLE_W'(avg)),
      .o_in_ready(f_ready),
      .o_out_valid(o_res_valid),
      .o_out_data(o_res_data),
      .i_out_ready(i_res_ready)
   );
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         o_status <= '0;
      else
      begin
         o_status.initiated <= state != twa_pkg::ACQ_IDLE;
         o_status.waiting_trigger <= state == twa_pkg::ACQ_ARMED;
         o_status.query_busy <= qst != twa_pkg::QRY_IDLE;
         o_status.record_valid <= rec_valid;
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   logic [11:0] gap;
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         gap <= 12'hfff; // Reaches BASE-1 at the first tick too
      else
         gap <= base_tick ? 12'h000 : gap + 12'h001;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   base_tick_gap_a: assert property (base_tick |-> gap == 12'(BASE - 1)) // RULE4
      else $error("Base tick spacing wrong");
   defaults_load_a: assert property (cv && i_cmd.op == twa_pkg::OP_RESET_DEF // RULE5
      |=> points == 13'd2048 && period_mult == 20'd1 && count == 13'd1)
      else $error("Defaults not loaded");
   period_round_a: assert property (cv && i_cmd.op == twa_pkg::OP_SET_PERIOD // RULE7
      && i_cmd.arg == 32'd30000 |=> period_mult == 20'd2)
      else $error("Interval rounding wrong");
   limit_err_a: assert property (cv && i_cmd.op == twa_pkg::OP_SET_POINTS // RULE10
      && i_cmd.arg == 32'd4097 |=> o_err && points == $past(points))
      else $error("Oversize record accepted");
   offset_keep_a: assert property (cv && i_cmd.op == twa_pkg::OP_SET_OFFSET // RULE21
      && $signed(i_cmd.arg) < -32'sd4096 |=> o_err && $stable(offset))
      else $error("Bad offset accepted");
   delay_no_store_a: assert property (state == twa_pkg::ACQ_DELAY |-> !mem_we) // RULE15
      else $error("Store during offset delay");
   idle_ignore_a: assert property (state == twa_pkg::ACQ_IDLE && !start_cmd // RULE19
      |=> state == twa_pkg::ACQ_IDLE)
      else $error("Idle system left without initiate");
   fetch_hold_a: assert property (qst == twa_pkg::QRY_WAIT // RULE20
      && state != twa_pkg::ACQ_IDLE |=> !o_status.query_busy || qst == twa_pkg::QRY_WAIT)
      else $error("Fetch answered early");
   rearm_a: assert property (finish && 13'(acq_idx) != count - 13'h0001 // RULE9
      |=> state == twa_pkg::ACQ_ARMED ##1 o_status.waiting_trigger)
      else $error("No re-arm between acquisitions");
   measure_c: cover property (cv && i_cmd.op == twa_pkg::OP_MEASURE ##1
      state == twa_pkg::ACQ_ARMED);
   multi_done_c: cover property (finish && count > 13'h0001 && 13'(acq_idx) == count - 13'h0001);
   pretrig_c: cover property (trig_now && offset < 0);
   array_stall_c: cover property (qst == twa_pkg::QRY_SCAN && pass == 2'd2 && !f_ready);
endmodule // twa_acq

// [conv_model.sv]
module conv_model (
   input wire logic i_clk_sys,
   input wire logic [15:0] i_level,
   output logic [15:0] o_sample
);
   timeunit 1ns;
   timeprecision 1ps;
   // Converter output follows the analog level one clock late
   always_ff @(posedge i_clk_sys)
      o_sample <= i_level;
endmodule // conv_model

// [triggered_waveform_acquisition_tb_top.sv]
module triggered_waveform_acquisition_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_rst, i_res_ready, o_res_valid, o_err, o_full_waveform_detector, e, cur;
   logic [15:0] lvl, samp, o_res_data, old;
   twa_pkg::cmd_t i_cmd;
   twa_pkg::status_t st;
   int miscompares, tests_run;
   logic [31:0] seed;
   conv_model conv (.i_clk_sys(i_clk_sys), .i_level(lvl), .o_sample(samp));
   twa_acq uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd(i_cmd), .i_conv_data(samp),
      .o_full_waveform_detector(o_full_waveform_detector), .o_conv_current(cur),
      .o_err(o_err), .o_status(st), .o_res_valid(o_res_valid), .o_res_data(o_res_data),
      .i_res_ready(i_res_ready));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Error pulse is gathered over a short window, its exact cycle is not fixed
   task automatic cmd(input twa_pkg::cmd_op_t op, input logic [31:0] arg);
      @(negedge i_clk_sys);
      i_cmd <= '{valid: 1'b1, op: op, arg: arg};
      @(negedge i_clk_sys);
      i_cmd.valid <= 1'b0;
      e = o_err;
      repeat (2) @(negedge i_clk_sys) e |= o_err;
   endtask
   task automatic query(input twa_pkg::cmd_op_t op, input int kind, input int n,
      input logic [15:0] exp);
      int k;
      cmd(op, 32'(kind));
      for (int i = 0; i < n; i++)
      begin
         k = 0;
         while (o_res_valid !== 1'b1 && k < 40000)
         begin
            @(negedge i_clk_sys);
            k++;
         end
         check(o_res_data, exp);
         i_res_ready <= 1'b1;
         @(negedge i_clk_sys);
         i_res_ready <= 1'b0;
         @(negedge i_clk_sys);
      end
   endtask
   task automatic results();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   initial
   begin
      // About 90000 cycles, some 18 sample ticks of work plus margin
      #360000;
      miscompares++;
      results();
   end
   initial
   begin
      seed = 32'hf68c;
      i_rst = 1'b1;
      i_cmd = '0;
      i_res_ready = 1'b0;
      lvl = 16'h0000;
      repeat (12) @(negedge i_clk_sys);
      i_rst = 1'b0;
      check(o_full_waveform_detector, 1'b1);
      check(o_err, 1'b0);
      check(cur, 1'b0);
      check(st, 4'h0);
      cmd(twa_pkg::OP_SET_DETECT, 32'h0);
      check(o_full_waveform_detector, 1'b0);
      cmd(twa_pkg::OP_RESET_DEF, 32'h0);
      check(o_full_waveform_detector, 1'b1);
      cmd(twa_pkg::OP_SET_PERIOD, 32'd30000);
      check(e, 1'b0);
      cmd(twa_pkg::OP_SET_PERIOD, 32'd15600);
      check(e, 1'b0);
      cmd(twa_pkg::OP_SET_DETECT, 32'h1);
      check(o_full_waveform_detector, 1'b1);
      $display("detector test done");
      cmd(twa_pkg::OP_SET_POINTS, 32'd4097);
      check(e, 1'b1);
      cmd(twa_pkg::OP_SET_POINTS, 32'd2);
      check(e, 1'b0);
      cmd(twa_pkg::OP_SET_COUNT, 32'd2049);
      check(e, 1'b1);
      cmd(twa_pkg::OP_SET_OFFSET, 32'd2000000001);
      check(e, 1'b1);
      cmd(twa_pkg::OP_SET_OFFSET, -32'sd4097);
      check(e, 1'b1);
      cmd(twa_pkg::OP_SET_OFFSET, -32'sd4096);
      check(e, 1'b0);
      cmd(twa_pkg::OP_SET_OFFSET, 32'd0);
      check(e, 1'b0);
      $display("limit test done");
      // Flat input makes every kind of result equal to the level
      for (int q = 1; q <= 4; q++)
      begin
         lvl = 16'(xs());
         old = lvl;
         query(twa_pkg::OP_MEASURE, q, 1, lvl);
      end
      lvl = ~old;
      query(twa_pkg::OP_FETCH, 0, 2, old);
      cmd(twa_pkg::OP_SET_OFFSET, 32'd2);
      query(twa_pkg::OP_MEASURE, 1, 1, lvl);
      $display("query test done");
      cmd(twa_pkg::OP_SET_FUNC, 32'h1);
      check(cur, 1'b1);
      cmd(twa_pkg::OP_SET_OFFSET, 32'd0);
      cmd(twa_pkg::OP_SET_COUNT, 32'd2);
      check(e, 1'b0);
      cmd(twa_pkg::OP_INIT, 32'h0);
      check(st, 4'hc);
      repeat (2)
      begin
         cmd(twa_pkg::OP_TRIGGER, 32'h0);
         while (st.waiting_trigger) @(negedge i_clk_sys);
         while (!st.waiting_trigger && st.initiated) @(negedge i_clk_sys);
      end
      check(st, 4'h1);
      query(twa_pkg::OP_FETCH, 1, 1, lvl);
      $display("multi test done");
      lvl = 16'h0050;
      cmd(twa_pkg::OP_SET_COUNT, 32'd1);
      cmd(twa_pkg::OP_SET_OFFSET, -32'sd1);
      cmd(twa_pkg::OP_SET_LEVEL, 32'h0100);
      cmd(twa_pkg::OP_SET_HYST, 32'h0020);
      cmd(twa_pkg::OP_SET_SOURCE, 32'h0);
      cmd(twa_pkg::OP_INIT, 32'h0);
      repeat (4000) @(negedge i_clk_sys);
      check(st, 4'hc);
      lvl = 16'h0200;
      query(twa_pkg::OP_FETCH, 1, 1, 16'h0200);
      query(twa_pkg::OP_FETCH, 2, 1, 16'h0050);
      query(twa_pkg::OP_FETCH, 3, 1, 16'h0200);
      $display("trigger test done");
      results();
   end
endmodule // triggered_waveform_acquisition_tb_top
